// *** dv/rtdp_comm_model.sv ***
// model: communication unit taking channel words byte by byte
`timescale 1ns/1ps
module rtdp_comm_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        stall,
  input  wire logic        tx_valid,
  input  wire logic [7:0]  tx_data,
  input  wire logic [1:0]  tx_channel,
  input  wire logic        tx_high_byte,
  output logic             tx_ready,
  output logic      [15:0] word [4],
  output logic      [3:0]  hi_first
);
  logic [1:0] pace;  // stall phase, ready one cycle in three
  logic       mid;   // first byte of a word already taken

  // slow mode still takes a whole word well inside one slot
  assign tx_ready = !stall || pace == 2'h0;

  // ==========================================================
  // byte capture into the four two-byte channel words
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pace     <= 2'h0;
      mid      <= 1'b0;
      hi_first <= 4'h0;
      word     <= '{default: 16'h0000};
    end
    else
    begin
      pace <= (pace == 2'h2) ? 2'h0 : pace + 2'h1;
      if (tx_valid && tx_ready)
      begin
        mid <= !mid;
        if (!mid)
          hi_first[tx_channel] <= tx_high_byte;
        if (tx_high_byte)
          word[tx_channel][15:8] <= tx_data;
        else
          word[tx_channel][7:0] <= tx_data;
      end
    end
  end
endmodule // rtdp_comm_model

// *** dv/rtdp_packer_props.sv ***
// checker: timing and framing properties of the rtd word packer
`timescale 1ns/1ps
module rtdp_packer_props #(
  parameter int TICK_CYCLES = 4  // cycles per tick
)(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        conv_start,
  input wire logic [1:0]  conv_channel,
  input wire logic        conv_three_wire,
  input wire logic [15:0] conv_value,
  input wire logic [15:0] conv_ohms,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic [1:0]  tx_channel,
  input wire logic        tx_high_byte,
  input wire logic        tx_ready
);
  localparam int CONV_CYC = 2400 * TICK_CYCLES;  // shortest window
  localparam int SLOT_CYC = 130 * TICK_CYCLES;   // one transfer slot
  int   conv_gap;   // cycles since last conversion start
  int   slot_gap;   // cycles since last word start
  logic conv_seen;  // a conversion started since reset
  logic word_seen;  // a word started since reset
  logic valid_q;    // offer flag one cycle back
  logic second;     // next byte taken closes a word

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================
  // helper counters, cleared by reset so no stale gap is judged
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      conv_gap  <= 0;
      slot_gap  <= 0;
      conv_seen <= 1'b0;
      word_seen <= 1'b0;
      valid_q   <= 1'b0;
      second    <= 1'b0;
    end
    else
    begin
      conv_gap  <= conv_start ? 1 : conv_gap + 1;
      conv_seen <= conv_seen | conv_start;
      slot_gap  <= (tx_valid && !valid_q) ? 1 : slot_gap + 1;
      word_seen <= word_seen | tx_valid;
      valid_q   <= tx_valid;
      if (tx_valid && tx_ready)
        second <= !second;
    end
  end

  // ==========================================================
  // byte transfer steps
  sequence byte_taken;
    tx_valid && tx_ready;
  endsequence
  sequence first_taken;
    byte_taken ##0 !second;
  endsequence
  sequence last_taken;
    byte_taken ##0 second;
  endsequence

  // ==========================================================
  // properties
  conv_win_a: assert property (
    conv_start && conv_seen |-> conv_gap >= CONV_CYC)
    else $error("conversion started before the window ended");
  conv_hold_a: assert property (
    conv_start |=> (!conv_start && $stable(conv_channel)
      && $stable(conv_three_wire))[*8])
    else $error("conversion channel moved inside its window");
  slot_period_a: assert property (
    tx_valid && !valid_q && word_seen |-> slot_gap % SLOT_CYC == 0)
    else $error("word start off the slot period");
  word_step_a: assert property (
    last_taken |=> !tx_valid && tx_channel == $past(tx_channel) + 2'h1)
    else $error("word did not end or channel did not advance");
  byte_hold_a: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
      && $stable(tx_high_byte) && $stable(tx_channel))
    else $error("offered byte changed before it was taken");
  byte_pair_a: assert property (
    first_taken |=> tx_valid && tx_high_byte != $past(tx_high_byte)
      && $stable(tx_channel))
    else $error("second byte of word missing or same half");
  // holds only while scaling stays inside the status window
  empty_bits_a: assert property (
    tx_valid && !tx_high_byte |-> !tx_data[0] && tx_data[3:2] == 2'h0)
    else $error("unused status bits set in low byte");
  slverr_phase_a: assert property (pslverr |-> psel && penable)
    else $error("slave error outside an access phase");
  ready_high_a: assert property (pready)
    else $error("pready dropped although no wait states exist");
endmodule // rtdp_packer_props

bind rtdp_packer rtdp_packer_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .conv_start(conv_start),
  .conv_channel(conv_channel), .conv_three_wire(conv_three_wire),
  .conv_value(conv_value), .conv_ohms(conv_ohms), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_channel(tx_channel),
  .tx_high_byte(tx_high_byte), .tx_ready(tx_ready));

// *** dv/rtdp_packer_tb.sv ***
// testbench: registers, conversion pacing and channel word stream
`timescale 1ns/1ps
module rtdp_packer_tb;
  localparam int TC   = 2;         // cycles per tick in simulation
  localparam int SLOT = 130 * TC;  // cycles per transfer slot
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        conv_start, conv_three_wire, tx_valid, tx_high_byte;
  logic        tx_ready, stall;
  logic [7:0]  paddr, tx_data;
  logic [31:0] pwdata, prdata;
  logic [1:0]  conv_channel, tx_channel;
  logic [15:0] conv_value, conv_ohms;
  logic [15:0] word [4];
  logic [3:0]  hi_first;
  int          n_mismatch = 0;
  int          checks = 0;
  int          starts = 0;
  int          pass_n = 0;
  int          cyc = 0;
  int          t_start [16];
  // raw results, loop ohms and expected words by pass and channel
  logic [15:0] vals [12] = '{16'h1234, 16'h5678, 16'h9ABC, 16'hDEF7,
    16'h2468, 16'hFFFF, 16'h1111, 16'h0000,
    16'h3579, 16'h4C2E, 16'h8001, 16'h6A3F};
  logic [15:0] ohms [12] = '{16'h03E8, 16'h0005, 16'h0064, 16'h0064,
    16'h0064, 16'h0064, 16'h07D0, 16'h0003,
    16'h0005, 16'h000A, 16'h07D0, 16'h0064};
  logic [15:0] exp_w [12] = '{16'h1230, 16'h5672, 16'h9AB0, 16'hDEF0,
    16'h2460, 16'hFFF2, 16'hA5A2, 16'h0000,
    16'h2462, 16'h4C20, 16'hA5A2, 16'h0000};

  rtdp_packer #(.TICK_CYCLES(TC)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_three_wire(conv_three_wire),
    .conv_value(conv_value), .conv_ohms(conv_ohms), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_channel(tx_channel),
    .tx_high_byte(tx_high_byte), .tx_ready(tx_ready));

  rtdp_comm_model u_model (
    .pclk(pclk), .presetn(presetn), .stall(stall), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_channel(tx_channel),
    .tx_high_byte(tx_high_byte), .tx_ready(tx_ready), .word(word),
    .hi_first(hi_first));

  // ==========================================================
  // clock, and the converter front end answering each start
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    int p;
    p = (conv_channel == 2'h0) ? pass_n : pass_n - 1;
    if (p > 2)
      p = 2;
    if (conv_start === 1'b1)
    begin
      conv_value <= vals[p * 4 + conv_channel];
      conv_ohms  <= ohms[p * 4 + conv_channel];
      if (conv_channel == 2'h0)
        pass_n <= pass_n + 1;
      if (starts < 16)
        t_start[starts] <= cyc;
      starts <= starts + 1;
    end
    cyc <= cyc + 1;
  end

  // ==========================================================
  // comparison, bus and closing tasks
  task automatic chk(input string what, input logic [31:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // holds the whole request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // only the watchdog ends a wait for an answer
    while (pready !== 1'b1)
      @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
    input logic xe);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk("read data", q, x);
    chk("slave error", 32'(e), 32'(xe));
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  // waits for a pass to begin, then for every slot to resend
  task automatic next_pass(input int k);
    for (int n = 0; n < 40000 && pass_n < k; n++)
      @(posedge pclk);
    chk("pass started", 32'(pass_n >= k), 32'h1);
    repeat (5 * SLOT) @(posedge pclk);
  endtask
  task automatic chk_pass(input int p);
    logic [15:0] x;
    for (int c = 0; c < 4; c++)
    begin
      x = exp_w[p * 4 + c];
      chk("stream word", 32'(word[c]), 32'(x));
      rd(8'(8'h18 + 4 * c), 32'(x), 1'b0);
      chk("high byte first", 32'(hi_first[c]), 32'h1);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================
  // main sequence: three passes with changing configuration
  initial
  begin
    {psel, penable, pwrite, stall, presetn} = 5'h00;
    paddr      = 8'h00;
    pwdata     = 32'h0000_0000;
    conv_value = 16'h0000;
    conv_ohms  = 16'h0000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h00, 32'h0000_0F0F, 1'b0);
    rd(8'h04, 32'h0000_0000, 1'b0);
    rd(8'h08, 32'h0000_0003, 1'b0);
    rd(8'h0C, 32'h0000_4E20, 1'b0);
    rd(8'h10, 32'h0000_0000, 1'b0);
    rd(8'h28, 32'h0000_0000, 1'b1);
    repeat (5 * SLOT) @(posedge pclk);
    chk("low byte first", 32'(hi_first), 32'h0);
    // second pass: all channels on, channel one three-wire
    wr(8'h00, 32'h0000_171F);
    wr(8'h04, 32'h0000_0012);
    wr(8'h08, 32'h0000_0002);
    wr(8'h10, 32'h0000_A5A0);
    rd(8'h00, 32'h0000_171F, 1'b0);
    next_pass(2);
    chk_pass(0);
    chk("window", 32'(t_start[1] - t_start[0] <= 2402*TC+2), 32'h1);
    stall <= 1'b1;
    wr(8'h00, 32'h0000_1707);
    wr(8'h0C, 32'h0000_2710);
    next_pass(3);
    chk_pass(1);
    chk("3w window", 32'(t_start[5] - t_start[4] >= 4800*TC), 32'h1);
    next_pass(4);
    chk_pass(2);
    results();
  end

  // watchdog: about half again the expected run length
  initial
  begin
    repeat (90000) @(posedge pclk);
    n_mismatch++;
    results();
  end
endmodule // rtdp_packer_tb

// *** rtl/rtdp_packer.sv ***
// module: rtd channel conversion scheduler, word packer and sender
`timescale 1ns/1ps
module rtdp_packer #(
  parameter int TICK_CYCLES = rtdp_pkg::TICK_CYCLES  // cycles per tick
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // converter front end
  output logic             conv_start,
  output logic      [1:0]  conv_channel,
  output logic             conv_three_wire,
  input  wire logic [15:0] conv_value,
  input  wire logic [15:0] conv_ohms,
  // byte stream towards the communication unit
  output logic             tx_valid,
  output logic      [7:0]  tx_data,
  output logic      [1:0]  tx_channel,
  output logic             tx_high_byte,
  input  wire logic        tx_ready
);

  // ==========================================================
  // functions
  // next enabled channel after cur, cyclic; cur if none other
  function automatic logic [1:0] next_chan(input logic [3:0] en,
                                           input logic [1:0] cur);
    logic [1:0] res;
    logic [1:0] cand;
    res = cur;
    for (int i = 3; i >= 1; i--)
    begin
      cand = 2'(cur + 2'(i));
      if (en[cand])
        res = cand;
    end
    return res;
  endfunction

  // build a channel word, with or without status nibble
  function automatic logic [15:0] pack(input logic [15:0] val,
                                       input logic        bad,
                                       input logic        keep_st);
    if (keep_st)
      return {val[15:4], 2'b00, bad, 1'b0};
    else
      return val;
  endfunction

  // ==========================================================
  // register file (shadow written by software)
  logic [12:0] ctrl_reg;     // enables, three-wire, lfd, word mode
  logic [7:0]  errm_reg;     // error mode per channel
  logic [7:0]  clrcnt_reg;   // fault_clear_cycle_count
  logic [15:0] scale_reg;    // configured scaling
  logic [15:0] subst_reg;    // substitute value
  // active copy used by the datapath
  logic [12:0] act_ctrl_reg;
  logic [7:0]  act_errm_reg;
  logic [7:0]  act_clrcnt_reg;
  logic [15:0] act_scale_reg;
  logic [15:0] act_subst_reg;

  logic        wr_en;        // access phase write
  logic        rd_setup;     // setup phase of any access, read or write
  logic        mapped;       // address decodes to a register
  logic [31:0] rd_val;       // read mux

  // per-channel state
  logic        invalid_reg [4];
  logic [7:0]  good_cnt_reg [4];
  logic [15:0] last_good_reg [4];
  logic [15:0] word_reg [4];
  logic [3:0]  fault_seen_reg;  // raw fault of last measurement

  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign pready   = 1'b1;  // zero wait states
  assign mapped   = (paddr[1:0] == 2'b00) &&
                    (paddr <= 8'(rtdp_pkg::OFS_DATA0 + 8'h0C));
  assign pslverr  = psel && penable && !mapped;

  // ==========================================================
  // register writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg   <= rtdp_pkg::CTRL_RST;
      errm_reg   <= rtdp_pkg::ERRM_RST;
      clrcnt_reg <= rtdp_pkg::CLRCNT_RST;
      scale_reg  <= rtdp_pkg::SCALE_RST;
      subst_reg  <= rtdp_pkg::SUBST_RST;
    end
    else if (wr_en)
    begin
      case (paddr)
        rtdp_pkg::OFS_CTRL:   ctrl_reg   <= pwdata[12:0];
        rtdp_pkg::OFS_ERRM:   errm_reg   <= pwdata[7:0];
        rtdp_pkg::OFS_CLRCNT: clrcnt_reg <= pwdata[7:0];
        rtdp_pkg::OFS_SCALE:  scale_reg  <= pwdata[15:0];
        rtdp_pkg::OFS_SUBST:  subst_reg  <= pwdata[15:0];
        default:              ;  // read-only or unmapped
      endcase
    end
  end

  // ==========================================================
  // read mux; prdata is captured in setup so it stands in access
  logic [1:0] conv_chan_reg;
  rtdp_pkg::rtdp_conv_type cv_state;
  logic [3:0] invalid_vec;

  generate
    for (genvar c = 0; c < 4; c++)
    begin : g_inv
      assign invalid_vec[c] = invalid_reg[c];
    end
  endgenerate

  always_comb
  begin
    rd_val = 32'h0000_0000;
    case (paddr)
      rtdp_pkg::OFS_CTRL:   rd_val = {19'h0, ctrl_reg};
      rtdp_pkg::OFS_ERRM:   rd_val = {24'h0, errm_reg};
      rtdp_pkg::OFS_CLRCNT: rd_val = {24'h0, clrcnt_reg};
      rtdp_pkg::OFS_SCALE:  rd_val = {16'h0, scale_reg};
      rtdp_pkg::OFS_SUBST:  rd_val = {16'h0, subst_reg};
      rtdp_pkg::OFS_STATUS:
        rd_val = {21'h0, cv_state != rtdp_pkg::CV_IDLE,
                  conv_chan_reg, fault_seen_reg, invalid_vec};
      default:
      begin
        // data words of channels one to four
        if (mapped && paddr >= rtdp_pkg::OFS_DATA0)
          rd_val = {16'h0,
                    word_reg[2'(8'(paddr - rtdp_pkg::OFS_DATA0) >> 2)]};
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_setup)
      prdata <= mapped ? rd_val : 32'h0000_0000;
  end

  // ==========================================================
  // tick divider: one-cycle enable every TICK_US
  logic [15:0] tick_cnt_reg;
  logic        tick;

  assign tick = (tick_cnt_reg == 16'(TICK_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_cnt_reg <= 16'h0000;
    else if (tick)
      tick_cnt_reg <= 16'h0000;
    else
      tick_cnt_reg <= 16'(tick_cnt_reg + 16'h0001);
  end

  // ==========================================================
  // conversion scheduler
  logic [12:0] conv_tmr_reg;  // ticks left in this conversion
  logic        meas_done;     // one-cycle pulse, result valid
  logic [1:0]  nxt;

  assign nxt        = next_chan(act_ctrl_reg[3:0], conv_chan_reg);
  assign meas_done  = (cv_state == rtdp_pkg::CV_WAIT) && tick &&
                      (conv_tmr_reg == 13'h0000);
  assign conv_start = (cv_state == rtdp_pkg::CV_START);
  assign conv_channel    = conv_chan_reg;
  assign conv_three_wire = act_ctrl_reg[rtdp_pkg::CTRL_3W_LSB +
                                        32'(conv_chan_reg)];

  // active configuration is loaded between passes; a pass lasts
  // at most 960 ms, well inside the allowed settling time
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      act_ctrl_reg   <= rtdp_pkg::CTRL_RST;
      act_errm_reg   <= rtdp_pkg::ERRM_RST;
      act_clrcnt_reg <= rtdp_pkg::CLRCNT_RST;
      act_scale_reg  <= rtdp_pkg::SCALE_RST;
      act_subst_reg  <= rtdp_pkg::SUBST_RST;
    end
    else if (cv_state == rtdp_pkg::CV_IDLE)
    begin
      act_ctrl_reg   <= ctrl_reg;
      act_errm_reg   <= errm_reg;
      act_clrcnt_reg <= clrcnt_reg;
      act_scale_reg  <= scale_reg;
      act_subst_reg  <= subst_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cv_state      <= rtdp_pkg::CV_IDLE;
      conv_chan_reg <= 2'h3;
      conv_tmr_reg  <= 13'h0000;
    end
    else
    begin
      case (cv_state)
        rtdp_pkg::CV_IDLE:
        begin
          // start a pass at the lowest enabled channel
          if (|ctrl_reg[3:0])
          begin
            conv_chan_reg <= next_chan(ctrl_reg[3:0], 2'h3);
            cv_state      <= rtdp_pkg::CV_START;
          end
        end
        rtdp_pkg::CV_START:
        begin
          if (conv_three_wire)
            conv_tmr_reg <= 13'(rtdp_pkg::CONV3W_TICKS - 1);
          else
            conv_tmr_reg <= 13'(rtdp_pkg::CONV_TICKS - 1);
          cv_state <= rtdp_pkg::CV_WAIT;
        end
        rtdp_pkg::CV_WAIT:
        begin
          if (tick)
          begin
            if (conv_tmr_reg != 13'h0000)
              conv_tmr_reg <= 13'(conv_tmr_reg - 13'h0001);
            else if (nxt <= conv_chan_reg)
              cv_state <= rtdp_pkg::CV_IDLE;  // pass complete
            else
            begin
              conv_chan_reg <= nxt;
              cv_state      <= rtdp_pkg::CV_START;
            end
          end
        end
        default: cv_state <= rtdp_pkg::CV_IDLE;
      endcase
    end
  end

  // ==========================================================
  // line fault detection and status packing, per channel
  logic fault_now;  // fault in the measurement just finished
  logic keep_st;    // scaling inside the status window

  assign fault_now = act_ctrl_reg[rtdp_pkg::CTRL_LFD_LSB +
                                  32'(conv_chan_reg)] &&
                     ((conv_ohms < rtdp_pkg::SHORT_OHMS) ||
                      (conv_ohms > rtdp_pkg::OPEN_OHMS));
  assign keep_st   = (act_scale_reg >= rtdp_pkg::SCALE_LO) &&
                     (act_scale_reg <= rtdp_pkg::SCALE_HI);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_seen_reg <= 4'h0;
    else if (meas_done)
      fault_seen_reg[conv_chan_reg] <= fault_now;
  end

  generate
    for (genvar c = 0; c < 4; c++)
    begin : g_chan
      logic       hit;       // this channel's result is in
      logic [7:0] cnt_inc;   // good count after this cycle
      logic       good_now;  // value may be signalled good
      logic [1:0] mode;      // error mode of this channel

      assign hit      = meas_done && (conv_chan_reg == 2'(c));
      assign cnt_inc  = 8'(good_cnt_reg[c] + 8'h01);
      assign good_now = !fault_now &&
                        (!invalid_reg[c] ||
                         cnt_inc >= act_clrcnt_reg);
      assign mode     = act_errm_reg[2*c +: 2];

      // debounce: invalid until enough clean cycles in a row
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          invalid_reg[c]  <= 1'b0;
          good_cnt_reg[c] <= 8'h00;
        end
        else if (hit)
        begin
          if (fault_now || !good_now)
          begin
            invalid_reg[c]  <= 1'b1;
            good_cnt_reg[c] <= fault_now ? 8'h00 : cnt_inc;
          end
          else
          begin
            invalid_reg[c]  <= 1'b0;
            good_cnt_reg[c] <= 8'h00;
          end
        end
      end

      // remembered value for last-valid error mode
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          last_good_reg[c] <= 16'h0000;
        else if (hit && good_now)
          last_good_reg[c] <= conv_value;
      end

      // packed channel word; inactive channels keep their word
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          word_reg[c] <= 16'h0000;
        else if (hit)
        begin
          if (good_now)
            word_reg[c] <= pack(conv_value, 1'b0, keep_st);
          else
          begin
            case (mode)
              rtdp_pkg::ERRM_SUBST:
                word_reg[c] <= pack(act_subst_reg, 1'b1,
                                    keep_st);
              rtdp_pkg::ERRM_LAST:
                word_reg[c] <= pack(last_good_reg[c], 1'b1, keep_st);
              default:
                word_reg[c] <= pack(conv_value, 1'b1, keep_st);
            endcase
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // transfer slots: one channel word per 6.5 ms slot
  logic [7:0]  slot_cnt_reg;
  logic        slot_go;
  rtdp_pkg::rtdp_tx_type tx_state;
  logic [15:0] tx_word_reg;  // word being sent
  logic        hi_first;     // word-by-word byte order

  assign slot_go  = tick &&
                    (slot_cnt_reg == 8'(rtdp_pkg::SLOT_TICKS - 1));
  assign hi_first = act_ctrl_reg[rtdp_pkg::CTRL_WORD_BIT];
  assign tx_valid = (tx_state != rtdp_pkg::TX_IDLE);

  // slot timer runs regardless of conversion progress
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      slot_cnt_reg <= 8'h00;
    else if (slot_go)
      slot_cnt_reg <= 8'h00;
    else if (tick)
      slot_cnt_reg <= 8'(slot_cnt_reg + 8'h01);
  end

  // a slot that finds the previous word still pending is dropped;
  // the channel pointer does not move, so no channel is skipped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state     <= rtdp_pkg::TX_IDLE;
      tx_channel   <= 2'h0;
      tx_word_reg  <= 16'h0000;
      tx_data      <= 8'h00;
      tx_high_byte <= 1'b0;
    end
    else
    begin
      case (tx_state)
        rtdp_pkg::TX_IDLE:
        begin
          if (slot_go)
          begin
            tx_word_reg  <= word_reg[tx_channel];
            tx_data      <= hi_first ? word_reg[tx_channel][15:8]
                                     : word_reg[tx_channel][7:0];
            tx_high_byte <= hi_first;
            tx_state     <= rtdp_pkg::TX_FIRST;
          end
        end
        rtdp_pkg::TX_FIRST:
        begin
          if (tx_ready)
          begin
            // follow the half already sent, not the live mode bit:
            // a config load between the bytes must not split a word
            tx_data      <= tx_high_byte ? tx_word_reg[7:0]
                                         : tx_word_reg[15:8];
            tx_high_byte <= !tx_high_byte;
            tx_state     <= rtdp_pkg::TX_SECOND;
          end
        end
        rtdp_pkg::TX_SECOND:
        begin
          if (tx_ready)
          begin
            tx_channel <= 2'(tx_channel + 2'h1);
            tx_state   <= rtdp_pkg::TX_IDLE;
          end
        end
        default: tx_state <= rtdp_pkg::TX_IDLE;
      endcase
    end
  end

endmodule // rtdp_packer

// *** rtl/rtdp_pkg.sv ***
// package: constants of the four-channel rtd readout and word packer
package rtdp_pkg;

  // ==========================================================
  // timebase
  localparam int CLK_KHZ      = 250000;  // pclk rate
  localparam int TICK_US      = 50;      // divider tick period
  localparam int TICK_CYCLES  = CLK_KHZ * TICK_US / 1000;
  localparam int CONV_MS      = 120;     // normal conversion
  localparam int CONV3W_MS    = 240;     // three-wire conversion
  localparam int SLOT_US      = 6500;    // transfer slot period
  localparam int CONV_TICKS   = CONV_MS * 1000 / TICK_US;
  localparam int CONV3W_TICKS = CONV3W_MS * 1000 / TICK_US;
  localparam int SLOT_TICKS   = SLOT_US / TICK_US;

  // ==========================================================
  // line fault thresholds in ohms
  localparam logic [15:0] SHORT_OHMS = 16'h000A;  // 10 ohms
  localparam logic [15:0] OPEN_OHMS  = 16'h03E8;  // 1000 ohms

  // ==========================================================
  // scaling window inside which status bits are carried
  localparam logic [15:0] SCALE_LO = 16'h2710;  // 10000
  localparam logic [15:0] SCALE_HI = 16'hC350;  // 50000

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ERRM   = 8'h04;
  localparam logic [7:0] OFS_CLRCNT = 8'h08;
  localparam logic [7:0] OFS_SCALE  = 8'h0C;
  localparam logic [7:0] OFS_SUBST  = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_DATA0  = 8'h18;  // data words 0x18..0x24

  // ctrl field positions
  localparam int CTRL_EN_LSB   = 0;   // [3:0] channel enable
  localparam int CTRL_3W_LSB   = 4;   // [7:4] three-wire
  localparam int CTRL_LFD_LSB  = 8;   // [11:8] line fault detect
  localparam int CTRL_WORD_BIT = 12;  // word-by-word transfer

  // reset values
  localparam logic [12:0] CTRL_RST   = 13'h0F0F;
  localparam logic [7:0]  ERRM_RST   = 8'h00;
  localparam logic [7:0]  CLRCNT_RST = 8'h03;
  localparam logic [15:0] SCALE_RST  = 16'h4E20;
  localparam logic [15:0] SUBST_RST  = 16'h0000;

  // error mode codes, two bits per channel
  localparam logic [1:0] ERRM_CURRENT = 2'h0;
  localparam logic [1:0] ERRM_SUBST   = 2'h1;
  localparam logic [1:0] ERRM_LAST    = 2'h2;

  typedef enum logic [1:0] {CV_IDLE, CV_START, CV_WAIT} rtdp_conv_type;
  typedef enum logic [1:0] {TX_IDLE, TX_FIRST, TX_SECOND} rtdp_tx_type;

endpackage
